// file: src/ppm_pkg.sv
// shared constants, mode type and decode function of the pin multiplexer
package ppm_pkg;
  // bus widths
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  // port index held in address bits 6:5
  localparam logic [1:0] PORT_1 = 2'h0;
  localparam logic [1:0] PORT_2 = 2'h1;
  localparam logic [1:0] PORT_3 = 2'h2;
  // register kind held in address bits 4:2
  localparam logic [2:0] KIND_OUT  = 3'h0;
  localparam logic [2:0] KIND_DIR  = 3'h1;
  localparam logic [2:0] KIND_SEL  = 3'h2;
  localparam logic [2:0] KIND_SEL2 = 3'h3;
  localparam logic [2:0] KIND_IN   = 3'h4;
  localparam logic [2:0] KIND_AE   = 3'h5;
  localparam logic [2:0] KIND_CD   = 3'h6;
  // reset values
  localparam logic [7:0] ZERO_RST   = 8'h00;
  localparam logic [7:0] P2_DIR_RST = 8'h80;
  localparam logic [7:0] P2_SEL_RST = 8'hC0;
  // pins that reach the package balls, per port
  localparam logic [7:0] EXT_MASK1 = 8'hFE;
  localparam logic [7:0] EXT_MASK2 = 8'hC6;
  localparam logic [7:0] EXT_MASK3 = 8'h28;
  // special bit positions
  localparam int XTAL_IN_BIT  = 6;
  localparam int XTAL_OUT_BIT = 7;
  localparam int TEST_BASE    = 4;
  localparam int TEST_DO_BIT  = 7;
  // pin role chosen by the three control bits
  typedef enum logic [2:0] {
    MODE_IO_IN    = 3'b000,
    MODE_IO_OUT   = 3'b001,
    MODE_PERI_IN  = 3'b010,
    MODE_PERI_OUT = 3'b011,
    MODE_CAPS     = 3'b100,
    MODE_MODULE   = 3'b101
  } ppm_mode_type;

  // decode direction, primary and secondary select into a role
  function automatic ppm_mode_type ppm_pin_mode(input logic d,
                                                input logic s,
                                                input logic s2);
    ppm_mode_type m;
    m = MODE_IO_IN;
    unique case ({s2, s})
      2'b00: m = d ? MODE_IO_OUT : MODE_IO_IN;
      2'b01: m = d ? MODE_PERI_OUT : MODE_PERI_IN;
      2'b10: m = MODE_CAPS;
      2'b11: m = MODE_MODULE;
    endcase
    return m;
  endfunction : ppm_pin_mode
endpackage : ppm_pkg

// file: src/ppm_pin_mux.sv
// pin function multiplexer for three 8-bit ports with a wishbone slave
`timescale 1ns/10ps
`default_nettype none
module ppm_pin_mux (
  // clock and reset
  input  wire  logic                       clk,
  input  wire  logic                       sys_rst,
  // wishbone slave
  input  wire  logic                       wb_cyc_i,
  input  wire  logic                       wb_stb_i,
  input  wire  logic                       wb_we_i,
  input  wire  logic [ppm_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire  logic [3:0]                 wb_sel_i,
  input  wire  logic [ppm_pkg::DAT_W-1:0]  wb_dat_i,
  output logic       [ppm_pkg::DAT_W-1:0]  wb_dat_o,
  output logic                             wb_ack_o,
  // pad levels, per port
  input  wire  logic [7:0]                 pin1In,
  input  wire  logic [7:0]                 pin2In,
  input  wire  logic [7:0]                 pin3In,
  output logic       [7:0]                 pin1Out,
  output logic       [7:0]                 pin1Oe,
  output logic       [7:0]                 pin2Out,
  output logic       [7:0]                 pin2Oe,
  output logic       [7:0]                 pin3Out,
  output logic       [7:0]                 pin3Oe,
  // peripheral sources
  input  wire  logic [2:0]                 timer0Out,
  input  wire  logic [2:0]                 timer1Out,
  input  wire  logic                       subSystemClock,
  input  wire  logic                       conversionClock,
  input  wire  logic                       comparatorResult,
  input  wire  logic                       crystalOutDrive,
  input  wire  logic [7:0]                 serialOut,
  input  wire  logic [7:0]                 serialOe,
  input  wire  logic                       jtagMode,
  input  wire  logic                       testDataOut,
  input  wire  logic                       testDataOutEn,
  // peripheral sinks
  output logic       [1:0]                 timer0Capture,
  output logic       [1:0]                 timer1Capture,
  output logic                             crystalIn,
  output logic       [7:0]                 serialIn,
  output logic                             testClock,
  output logic                             testModeSelect,
  output logic                             testDataIn,
  output logic       [7:0]                 analogConnect,
  output logic       [7:0]                 comparatorConnect,
  output logic       [7:0]                 capSense1,
  output logic       [7:0]                 capSense2,
  output logic       [7:0]                 capSense3,
  // power core control lines
  output logic                             leftBridgeCtrl1,
  output logic                             leftBridgeCtrl2,
  output logic                             rightBridgeCtrl1,
  output logic                             rightBridgeCtrl2,
  output logic                             powerDownRequest,
  output logic                             chargerEnableLine,
  output logic                             boostEnableLine
);
  import ppm_pkg::*;

  // software control registers, index 0..2 for ports 1..3
  logic [2:0][7:0] outR;       // output latch
  logic [2:0][7:0] dirR;       // direction
  logic [2:0][7:0] selR;       // primary select
  logic [2:0][7:0] sel2R;      // secondary select
  logic      [7:0] aeR;        // analog channel enable, port 1 only
  logic      [7:0] cdR;        // comparator input disable, port 1 only
  // mux results
  logic [2:0][7:0] next_pinOut;
  logic [2:0][7:0] next_pinOe;
  logic [2:0][7:0] next_caps;
  logic [2:0][7:0] intVal;     // value a pin would put on its line
  logic [2:0][7:0] periIn;     // pin routed to a peripheral input
  logic [2:0][7:0] pinOutR;
  logic [2:0][7:0] pinOeR;
  logic [2:0][7:0] capsR;
  logic [2:0][7:0] pinIn;      // pad levels gathered
  // bus decode
  logic       access;          // new request this cycle
  logic [1:0] adrPort;
  logic [2:0] adrKind;
  logic       mapped;
  logic [7:0] next_rdata;

  assign pinIn   = {pin3In, pin2In, pin1In};
  assign adrPort = wb_adr_i[6:5];
  assign adrKind = wb_adr_i[4:2];
  assign access  = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // ext pin mask for a port
  function automatic logic [7:0] ext_mask(input int p);
    logic [7:0] m;
    m = EXT_MASK3;
    if (p == 0) m = EXT_MASK1;
    else if (p == 1) m = EXT_MASK2;
    return m;
  endfunction : ext_mask

  // peripheral output bound to a pin, zero where none exists
  function automatic logic periph_out(input int p, input int x);
    logic v;
    v = 1'b0;
    if (p == 0) begin
      case (x)
        1, 5: v = timer0Out[0];
        2, 6: v = timer0Out[1];
        3: v = conversionClock;
        4: v = subSystemClock;
        7: v = comparatorResult;
        default: v = 1'b0;
      endcase
    end else if (p == 1) begin
      case (x)
        0, 3: v = timer1Out[0];
        4, 5: v = timer1Out[2];
        1, 2: v = timer1Out[1];
        XTAL_IN_BIT: v = timer0Out[1];
        XTAL_OUT_BIT: v = crystalOutDrive;
        default: v = 1'b0;
      endcase
    end else begin
      case (x)
        0, 5: v = timer0Out[2];
        1, 2, 3: v = timer1Out[2];
        default: v = 1'b0;
      endcase
    end
    return v;
  endfunction : periph_out

  // per-pin role decode and routing
  always_comb begin
    ppm_mode_type md;
    md = MODE_IO_IN;
    next_pinOut = '0;
    next_pinOe  = '0;
    next_caps   = '0;
    intVal      = '0;
    periIn      = '0;
    for (int p = 0; p < 3; p++) begin
      for (int x = 0; x < 8; x++) begin
        md = ppm_pin_mode(dirR[p][x], selR[p][x], sel2R[p][x]);
        unique case (md)
          // plain output drives the latch
          MODE_IO_OUT: begin
            intVal[p][x] = outR[p][x];
            next_pinOut[p][x] = outR[p][x];
            next_pinOe[p][x] = 1'b1;
          end
          // peripheral output, direction 1 and select 1
          MODE_PERI_OUT: begin
            intVal[p][x] = periph_out(p, x);
            next_pinOut[p][x] = periph_out(p, x);
            next_pinOe[p][x] = 1'b1;
          end
          // peripheral input, direction 0 and select 1
          MODE_PERI_IN: periIn[p][x] = 1'b1;
          // oscillator mode, direction ignored
          MODE_CAPS: next_caps[p][x] = 1'b1;
          // serial module owns the driver on port 1
          MODE_MODULE: begin
            if (p == 0) begin
              next_pinOut[p][x] = serialOut[x];
              next_pinOe[p][x] = serialOe[x];
            end
          end
          default: ;
        endcase
      end
      // internal-only and absent pins never reach a pad
      next_pinOe[p] = next_pinOe[p] & ext_mask(p);
      next_caps[p] = next_caps[p] & ext_mask(p);
    end
    // analog hookups turn off the port 1 drivers and sensing of every pin role, except the test data out driver on bit 7 in test mode
    next_pinOe[0] = next_pinOe[0] & ~(aeR | cdR);
    next_caps[0]  = next_caps[0] & ~(aeR | cdR);
    // test mode takes the upper four port 1 pins
    if (jtagMode) begin
      for (int x = TEST_BASE; x < 8; x++) begin
        next_pinOe[0][x] = 1'b0;
      end
      next_pinOe[0][TEST_DO_BIT] = testDataOutEn;
      next_pinOut[0][TEST_DO_BIT] = testDataOut;
    end
  end

  // write strobe for the low byte lane
  logic wrLow;
  assign wrLow = access && wb_we_i && wb_sel_i[0];

  // latch, direction and select registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      outR  <= {ZERO_RST, ZERO_RST, ZERO_RST};
      dirR  <= {ZERO_RST, P2_DIR_RST, ZERO_RST};
      selR  <= {ZERO_RST, P2_SEL_RST, ZERO_RST};
      sel2R <= {ZERO_RST, ZERO_RST, ZERO_RST};
    end else if (wrLow && adrPort != 2'h3) begin
      // port 4 slot is unmapped, writes there are dropped
      case (adrKind)
        KIND_OUT:  outR[adrPort]  <= wb_dat_i[7:0];
        KIND_DIR:  dirR[adrPort]  <= wb_dat_i[7:0];
        KIND_SEL:  selR[adrPort]  <= wb_dat_i[7:0];
        KIND_SEL2: sel2R[adrPort] <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // analog enables live on port 1 only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aeR <= ZERO_RST;
      cdR <= ZERO_RST;
    end else if (wrLow && adrPort == PORT_1) begin
      if (adrKind == KIND_AE) aeR <= wb_dat_i[7:0];
      if (adrKind == KIND_CD) cdR <= wb_dat_i[7:0];
    end
  end

  // read mux, unmapped reads give zero
  always_comb begin
    mapped = (adrPort != 2'h3) && (adrKind <= KIND_IN);
    if (adrPort == PORT_1 && (adrKind == KIND_AE || adrKind == KIND_CD))
      mapped = 1'b1;
    next_rdata = 8'h00;
    if (mapped) begin
      case (adrKind)
        KIND_OUT:  next_rdata = outR[adrPort];
        KIND_DIR:  next_rdata = dirR[adrPort];
        KIND_SEL:  next_rdata = selR[adrPort];
        KIND_SEL2: next_rdata = sel2R[adrPort];
        KIND_IN:   next_rdata = pinIn[adrPort];
        KIND_AE:   next_rdata = aeR;
        KIND_CD:   next_rdata = cdR;
        default:   next_rdata = 8'h00;
      endcase
    end
  end

  // bus answer, one ack per request, registered one cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      if (access) wb_dat_o <= {24'h00_0000, next_rdata};
    end
  end

  // registered pad drive
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinOutR <= '0;
      pinOeR  <= '0;
      capsR   <= '0;
    end else begin
      pinOutR <= next_pinOut;
      pinOeR  <= next_pinOe;
      capsR   <= next_caps;
    end
  end

  assign pin1Out   = pinOutR[0];
  assign pin2Out   = pinOutR[1];
  assign pin3Out   = pinOutR[2];
  assign pin1Oe    = pinOeR[0];
  assign pin2Oe    = pinOeR[1];
  assign pin3Oe    = pinOeR[2];
  assign capSense1 = capsR[0];
  assign capSense2 = capsR[1];
  assign capSense3 = capsR[2];

  // internal power core lines, idle low when not driven
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      leftBridgeCtrl1   <= 1'b0;
      leftBridgeCtrl2   <= 1'b0;
      rightBridgeCtrl1  <= 1'b0;
      rightBridgeCtrl2  <= 1'b0;
      powerDownRequest  <= 1'b0;
      chargerEnableLine <= 1'b0;
      boostEnableLine   <= 1'b0;
    end else begin
      leftBridgeCtrl1   <= intVal[1][0];
      leftBridgeCtrl2   <= intVal[1][3];
      rightBridgeCtrl1  <= intVal[1][4];
      rightBridgeCtrl2  <= intVal[1][5];
      powerDownRequest  <= intVal[2][0];
      chargerEnableLine <= intVal[2][1];
      boostEnableLine   <= intVal[2][2];
    end
  end

  // peripheral inputs taken from the pads, analog and comparator connections from the enable registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer0Capture     <= 2'h0;
      timer1Capture     <= 2'h0;
      crystalIn         <= 1'b0;
      serialIn          <= 8'h00;
      testClock         <= 1'b0;
      testModeSelect    <= 1'b0;
      testDataIn        <= 1'b0;
      analogConnect     <= 8'h00;
      comparatorConnect <= 8'h00;
    end else begin
      timer0Capture <= periIn[0][2:1] & pin1In[2:1];
      timer1Capture <= periIn[1][2:1] & pin2In[2:1];
      crystalIn <= periIn[1][XTAL_IN_BIT] & pin2In[XTAL_IN_BIT];
      serialIn <= pin1In;
      testClock      <= jtagMode & pin1In[TEST_BASE];
      testModeSelect <= jtagMode & pin1In[TEST_BASE + 1];
      testDataIn     <= jtagMode & pin1In[TEST_BASE + 2];
      analogConnect     <= aeR;
      comparatorConnect <= cdR & ~aeR;
    end
  end

  // checks on the routing
  a_left_bridge_io: assert property (@(posedge clk) disable iff (sys_rst)
    (dirR[1][0] && !selR[1][0] && !sel2R[1][0])
    |=> leftBridgeCtrl1 == $past(outR[1][0]))
    else $error("left bridge line 1 not following latch");
  a_sleep_timer: assert property (@(posedge clk) disable iff (sys_rst)
    (dirR[2][0] && selR[2][0] && !sel2R[2][0])
    |=> powerDownRequest == $past(timer0Out[2]))
    else $error("power-down line not on timer0 out2");
  a_boost_line: assert property (@(posedge clk) disable iff (sys_rst)
    (!dirR[2][2] && !sel2R[2][2]) |=> !boostEnableLine)
    else $error("boost line driven while input");
  a_analog_oe_off: assert property (@(posedge clk) disable iff (sys_rst)
    (aeR[3] || cdR[3]) |=> !pin1Oe[3])
    else $error("pad driven while analog hooked up");
  a_caps_mode: assert property (@(posedge clk) disable iff (sys_rst)
    (!selR[1][6] && sel2R[1][6]) |=> (capSense2[6] && !pin2Oe[6]))
    else $error("capacitive sensing not entered");
  a_serial_oe: assert property (@(posedge clk) disable iff (sys_rst)
    (selR[0][2] && sel2R[0][2] && !jtagMode && !aeR[2] && !cdR[2])
    |=> pin1Oe[2] == $past(serialOe[2]))
    else $error("serial module not owning direction");
  a_capture_t1: assert property (@(posedge clk) disable iff (sys_rst)
    (!dirR[1][1] && selR[1][1] && !sel2R[1][1])
    |=> timer1Capture[0] == $past(pin2In[1]))
    else $error("timer1 capture not routed");
  a_p33_timer: assert property (@(posedge clk) disable iff (sys_rst)
    (dirR[2][3] && selR[2][3] && !sel2R[2][3])
    |=> (pin3Oe[3] && pin3Out[3] == $past(timer1Out[2])))
    else $error("timer1 out2 missing on port3 bit3");
  a_subclk_out: assert property (@(posedge clk) disable iff (sys_rst)
    (dirR[0][4] && selR[0][4] && !sel2R[0][4] && !jtagMode
     && !aeR[4] && !cdR[4])
    |=> (pin1Oe[4] && pin1Out[4] == $past(subSystemClock)))
    else $error("sub-system clock not on port1 bit4");
  a_test_pins: assert property (@(posedge clk) disable iff (sys_rst)
    jtagMode |=> (!pin1Oe[4] && !pin1Oe[5] && !pin1Oe[6]))
    else $error("test pins still driven");
  a_xtal_reset: assert property (@(posedge clk)
    $fell(sys_rst) |-> (dirR[1][7] && selR[1][7] && !dirR[0][1]))
    else $error("reset pin roles wrong");
endmodule : ppm_pin_mux
`default_nettype wire

// file: verification/ppm_power_core.sv
// power core and board model on the far side of the pin multiplexer
`timescale 1ns/10ps
`default_nettype none
module ppm_power_core (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // power-down request from the mux
  input  wire logic        powerDownRequest,
  // pad drive from the mux, port 3 on top
  input  wire logic [23:0] padOut,
  input  wire logic [23:0] padOe,
  // levels the board puts on undriven pads
  input  wire logic [23:0] board,
  // resolved pad levels and power state
  output logic      [23:0] pad,
  output logic             poweredOff
);
  logic lastPd;  // power-down level one cycle ago

  // a driven pad shows the mux value, an undriven one the board level
  assign pad = (padOe & padOut) | (~padOe & board);

  // system shuts off on a falling power-down line, and stays off
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lastPd     <= 1'b0;
      poweredOff <= 1'b0;
    end else begin
      lastPd <= powerDownRequest;
      if (lastPd && !powerDownRequest) begin  // falling edge
        poweredOff <= 1'b1;
      end
    end
  end
endmodule : ppm_power_core
`default_nettype wire

// file: verification/ppm_pin_mux_tb.sv
// self-checking testbench of the pin function multiplexer
`timescale 1ns/10ps
`default_nettype none
module ppm_pin_mux_tb;
  import ppm_pkg::*;
  // clock, reset and bus master
  logic clk, sys_rst, wbCyc, wbStb, wbWe;
  logic [ADR_W-1:0] wbAdr;
  logic [3:0]       wbSel;
  logic [DAT_W-1:0] wbDatW;
  wire  [DAT_W-1:0] wbDatR;
  wire              wbAck;
  // pads and board
  wire  [23:0] padOut, padOe, pad;
  logic [23:0] board;
  wire         poweredOff;
  // peripheral sources
  logic [2:0] t0Out, t1Out;
  logic       sub_system_clock, cvClk, cmpRes, xoDrv, jtag, tdo, tdoEn;
  logic [7:0] serOut, serOe;
  // peripheral sinks
  wire [1:0] t0Cap, t1Cap;
  wire       crystal_in, tck, tms, tdi;
  wire [7:0] serIn, anaCon, cmpCon, cap1, cap2, cap3;
  wire       lb1, lb2, rb1, rb2, pdReq, chgEn, bstEn;
  // bookkeeping
  int n_mismatch, checked, cycles;
  logic [31:0] q;

  ppm_pin_mux ppm_pin_mux_inst (
    .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .pin1In(pad[7:0]),
    .pin2In(pad[15:8]), .pin3In(pad[23:16]), .pin1Out(padOut[7:0]),
    .pin1Oe(padOe[7:0]), .pin2Out(padOut[15:8]), .pin2Oe(padOe[15:8]),
    .pin3Out(padOut[23:16]), .pin3Oe(padOe[23:16]), .timer0Out(t0Out),
    .timer1Out(t1Out), .subSystemClock(sub_system_clock), .conversionClock(cvClk),
    .comparatorResult(cmpRes), .crystalOutDrive(xoDrv), .serialOut(serOut),
    .serialOe(serOe), .jtagMode(jtag), .testDataOut(tdo),
    .testDataOutEn(tdoEn), .timer0Capture(t0Cap), .timer1Capture(t1Cap),
    .crystalIn(crystal_in), .serialIn(serIn), .testClock(tck),
    .testModeSelect(tms), .testDataIn(tdi), .analogConnect(anaCon),
    .comparatorConnect(cmpCon), .capSense1(cap1), .capSense2(cap2),
    .capSense3(cap3), .leftBridgeCtrl1(lb1), .leftBridgeCtrl2(lb2),
    .rightBridgeCtrl1(rb1), .rightBridgeCtrl2(rb2),
    .powerDownRequest(pdReq), .chargerEnableLine(chgEn),
    .boostEnableLine(bstEn));

  ppm_power_core ppm_power_core_inst (
    .clk(clk), .sys_rst(sys_rst), .powerDownRequest(pdReq),
    .padOut(padOut), .padOe(padOe), .board(board), .pad(pad),
    .poweredOff(poweredOff));

  // closing report and verdict
  task automatic test_done();
    $display("checked %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // compare a value against its expectation
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic wishbone cycle; waits for ack, then releases
  task automatic wb(input logic w, input logic [1:0] p, input logic [2:0] k,
                    input logic [7:0] d);
    @(posedge clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= w;
    wbAdr  <= {1'b0, p, k, 2'b00};
    wbDatW <= {24'h000000, d};
    wbSel  <= 4'hF;
    do @(posedge clk); while (wbAck !== 1'b1);
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask : wb

  // read a register and compare it
  task automatic rd(input logic [1:0] p, input logic [2:0] k,
                    input logic [7:0] e);
    wb(1'b0, p, k, 8'h00);
    chk(q, {24'h000000, e});
  endtask : rd

  // let registered outputs follow their causes
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // clock of 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      test_done();
    end
  end

  // main sequence
  initial begin
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} = '0;
    {board, t0Out, t1Out, sub_system_clock, cvClk, cmpRes, jtag, tdo, tdoEn} = '0;
    {serOut, serOe} = '0;
    xoDrv   = 1'b1;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    settle();
    // oscillator output owns port 2 bit 7 out of reset
    chk({padOe[15], padOut[15]}, 2'b11);
    for (int p = 0; p < 3; p++) begin
      for (int k = 1; k < 4; k++) begin
        q = 32'h0;
        if (p == 1 && k == 1) q = 32'h80;
        if (p == 1 && k == 2) q = 32'hC0;
        rd(p[1:0], k[2:0], q[7:0]);
      end
    end
    rd(PORT_1, KIND_AE, 8'h00);
    // unmapped port: write ignored, reads zero
    wb(1'b1, 2'h3, KIND_DIR, 8'hFF);
    rd(2'h3, KIND_DIR, 8'h00);
    // crystal input and port 2 capture inputs
    wb(1'b1, PORT_2, KIND_SEL, 8'hC6);
    @(posedge clk);
    board <= 24'h004204;
    settle();
    chk({crystal_in, t1Cap}, 3'b101);
    wb(1'b1, PORT_1, KIND_SEL, 8'h06);
    settle();
    chk(t0Cap, 2'b10);
    // bridge lines as plain outputs, then timer 1 outputs
    wb(1'b1, PORT_2, KIND_DIR, 8'hB9);
    wb(1'b1, PORT_2, KIND_OUT, 8'h11);
    settle();
    chk({rb2, rb1, lb2, lb1}, 4'b0101);
    wb(1'b1, PORT_2, KIND_SEL, 8'hF9);
    @(posedge clk);
    t1Out <= 3'b001;
    settle();
    chk({rb2, rb1, lb2, lb1}, 4'b0011);
    // power lines as plain outputs; falling power-down seen by core
    wb(1'b1, PORT_3, KIND_DIR, 8'h2F);
    wb(1'b1, PORT_3, KIND_OUT, 8'h07);
    settle();
    chk({bstEn, chgEn, pdReq, poweredOff}, 4'b1110);
    wb(1'b1, PORT_3, KIND_OUT, 8'h06);
    settle();
    chk({bstEn, chgEn, pdReq, poweredOff}, 4'b1101);
    // timer outputs on port 3, two source patterns
    wb(1'b1, PORT_3, KIND_SEL, 8'h2F);
    @(posedge clk);
    t0Out <= 3'b100;
    t1Out <= 3'b000;
    settle();
    chk({bstEn, chgEn, pdReq, padOut[21], padOut[19]}, 5'b00110);
    @(posedge clk);
    t0Out <= 3'b000;
    t1Out <= 3'b100;
    settle();
    chk({bstEn, chgEn, pdReq, padOut[21], padOut[19]}, 5'b11001);
    chk(padOe[23:16] & 8'h28, 8'h28);
    // port 1 clock and comparator outputs
    wb(1'b1, PORT_1, KIND_DIR, 8'h98);
    wb(1'b1, PORT_1, KIND_SEL, 8'h98);
    @(posedge clk);
    {sub_system_clock, cvClk, cmpRes} <= 3'b110;
    settle();
    chk({padOe[7:0] & 8'h98, padOut[7:0] & 8'h98}, 16'h9818);
    @(posedge clk);
    {sub_system_clock, cvClk, cmpRes} <= 3'b001;
    settle();
    chk(padOut[7:0] & 8'h98, 8'h80);
    // analog and comparator connections override digital roles
    wb(1'b1, PORT_1, KIND_AE, 8'h08);
    wb(1'b1, PORT_1, KIND_CD, 8'h18);
    settle();
    chk({anaCon, cmpCon, padOe[7:0] & 8'h98}, 24'h081080);
    rd(PORT_1, KIND_CD, 8'h18);
    wb(1'b1, PORT_1, KIND_AE, 8'h00);
    wb(1'b1, PORT_1, KIND_CD, 8'h00);
    // serial module owns direction when both selects set
    wb(1'b1, PORT_1, KIND_SEL, 8'hFE);
    wb(1'b1, PORT_1, KIND_SEL2, 8'hFE);
    @(posedge clk);
    serOe  <= 8'hA5;
    serOut <= 8'hFF;
    settle();
    chk({padOe[7:0], padOut[7:0] & padOe[7:0]}, 16'hA4A4);
    // capacitive sensing whatever the direction bits say
    wb(1'b1, PORT_1, KIND_DIR, 8'hFF);
    wb(1'b1, PORT_1, KIND_SEL, 8'h00);
    settle();
    chk(cap1, EXT_MASK1);
    // ports 2 and 3 enter capacitive sensing on their outside pins only
    wb(1'b1, PORT_2, KIND_SEL, 8'h00);
    wb(1'b1, PORT_2, KIND_SEL2, 8'hFF);
    wb(1'b1, PORT_3, KIND_SEL, 8'h00);
    wb(1'b1, PORT_3, KIND_SEL2, 8'hFF);
    settle();
    chk({cap2, cap3, padOe[15:8]}, 24'hC62800);
    wb(1'b1, PORT_1, KIND_SEL2, 8'h00);
    // test mode takes port 1 bits 4 to 7
    @(posedge clk);
    board <= 24'h000070;
    {jtag, tdo, tdoEn} <= 3'b111;
    settle();
    chk({tck, tms, tdi, padOe[7:4], padOut[7]}, 8'hF1);
    chk(serIn, 8'hF0);
    rd(PORT_1, KIND_IN, 8'hF0);
    test_done();
  end
endmodule : ppm_pin_mux_tb
`default_nettype wire
